/* File: clock_source_pkg.sv */
// constants for the cpu clock source control block
// assumes a 100 MHz core clock and a 4-bit cpu i/o bus with 16-bit addresses
package clock_source_pkg;

	// i/o address of the oscillator clock control register
	localparam logic [15:0] OSC_CTL_ADDR      = 16'hFF00;
	// field positions inside the control register
	localparam int          CPU_SEL_BIT       = 3;
	localparam int          FAST_EN_BIT       = 2;
	// reset value: slow source selected, fast oscillator off
	localparam logic [3:0]  OSC_CTL_RESET     = 4'h0;
	// read value of the unused low bits
	localparam logic [1:0]  UNUSED_READ       = 2'h0;

	// core clock period
	localparam int          CORE_PERIOD_NS    = 10;
	// oscillator rates, R4
	localparam int          SLOW_OSC_HZ       = 32768;
	localparam int          FAST_OSC_MAX_HZ   = 4200000;
	localparam int          FAST_OSC_CR_MAX_HZ = 2000000;
	// shortest fast oscillator start-up time, in ms
	localparam int          FAST_STABLE_MS    = 1;
	// least time rounds up to whole core cycles
	localparam int          FAST_STABLE_CYCLES = (FAST_STABLE_MS * 1000000 + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

	// cpu clock source
	typedef enum logic {
		SRC_SLOW = 1'b0,
		SRC_FAST = 1'b1
	} clk_src_t;

endpackage

/* File: cpu_clock_source_control.sv */
// cpu clock source control: control register, oscillator gating, clock mux
// assumes the cpu bus is synchronous to CORE_CLK; oscillator outputs arrive as pins
//
// Notes on behaviour
// R1: reset selects the slow source, select bit cleared
// R2: enable bit 2 runs or stops fast oscillator
// R3: select bit 3 picks fast or slow clock
// R4: slow 32.768 kHz, fast up to 4.2/2 MHz
// R5: fast oscillator stops on sleep or enable 0
// R6: sleep stops both oscillators
// R7: slow clock keeps feeding timers while fast runs
// R8: software selects slow clock before sleeping
// R9: software waits for fast start-up before selecting
// R10: software clears select and enable separately
// R11: fast oscillator may stop right after return
// R12: software keeps fast oscillator off when unused
// R13: bits 1 and 0 read zero, ignore writes
// R14: standby resumes with the same clock configuration
// R15: slow-only systems leave bits at reset
// R16: glitch-free switch, only onto a stable oscillator; code drops to slow at once when fast stops
`timescale 1ns/1ns

module cpu_clock_source_control #(
	parameter int STABLE_CYCLES = clock_source_pkg::FAST_STABLE_CYCLES, // fast start-up wait
	parameter int STABLE_W      = 20                                     // start-up counter width
) (
	input  wire logic        CORE_CLK,
	input  wire logic        RST,
	input  wire logic [15:0] IO_ADDR,
	input  wire logic        IO_WR,
	input  wire logic        IO_RD,
	input  wire logic [3:0]  IO_WDATA,
	output      logic [3:0]  IO_RDATA,
	input  wire logic        SLEEP_EXEC,
	input  wire logic        WAKE_EVENT,
	input  wire logic        SLOW_OSC_IN,
	input  wire logic        FAST_OSC_IN,
	output      logic        SLOW_OSC_EN,
	output      logic        FAST_OSC_EN,
	output      logic        FAST_OSC_READY,
	output      logic        CPU_ON_FAST,
	output      logic        CPU_CLK,
	output      logic        TIMER_CLK
);

	// i/o address decode, used by read and write paths
	function automatic logic hits_ctl(input logic [15:0] addr);
		hits_ctl = (addr == clock_source_pkg::OSC_CTL_ADDR);
	endfunction

	// stored control bits
	logic                       cpu_sel_reg;     // cpu clock select
	logic                       fast_en_reg;     // fast oscillator enable
	logic                       sleep_reg;       // cpu in sleep
	logic [STABLE_W-1:0]        stable_cnt_reg;  // fast start-up counter
	logic                       stable_reg;      // fast oscillator settled
	clock_source_pkg::clk_src_t src_reg;         // source now driving the cpu
	clock_source_pkg::clk_src_t src_next;        // source for next cycle

	// pin synchronisers, three stages each
	logic [2:0]                 slow_sync_reg;   // slow oscillator samples
	logic [2:0]                 fast_sync_reg;   // fast oscillator samples
	logic                       slow_lvl_reg;    // filtered slow level
	logic                       fast_lvl_reg;    // filtered fast level

	// decode wires
	wire                        wr_hit     = IO_WR && hits_ctl(IO_ADDR);
	wire                        rd_hit     = IO_RD && hits_ctl(IO_ADDR);
	wire                        sleep_next = (sleep_reg || SLEEP_EXEC) && !WAKE_EVENT;
	wire                        fast_run   = fast_en_reg && !sleep_reg;
	wire [STABLE_W-1:0]         stable_max = STABLE_W'(STABLE_CYCLES);
	wire                        want_fast  = cpu_sel_reg && fast_run && stable_reg;
	wire                        both_low   = !slow_lvl_reg && !fast_lvl_reg;
	wire [3:0]                  ctl_view   = {cpu_sel_reg, fast_en_reg, clock_source_pkg::UNUSED_READ};
	wire                        src_clk    = (src_reg == clock_source_pkg::SRC_FAST) ? fast_lvl_reg : slow_lvl_reg;

	// control register; sleep leaves it untouched
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			cpu_sel_reg <= clock_source_pkg::OSC_CTL_RESET[clock_source_pkg::CPU_SEL_BIT]; // R1
			fast_en_reg <= clock_source_pkg::OSC_CTL_RESET[clock_source_pkg::FAST_EN_BIT];
		end else if (wr_hit) begin
			// low bits are not stored
			cpu_sel_reg <= IO_WDATA[clock_source_pkg::CPU_SEL_BIT]; // R3
			fast_en_reg <= IO_WDATA[clock_source_pkg::FAST_EN_BIT]; // R2
		end
	end

	// read data, low bits always zero
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			IO_RDATA <= 4'h0;
		end else begin
			IO_RDATA <= rd_hit ? ctl_view : 4'h0; // R13
		end
	end

	// sleep state, held from sleep instruction until wake
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			sleep_reg <= 1'b0;
		end else begin
			sleep_reg <= sleep_next; // R14
		end
	end

	// fast enable follows its bit, slow enable stays on outside sleep, both drop in sleep
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			SLOW_OSC_EN <= 1'b0;
			FAST_OSC_EN <= 1'b0;
		end else begin
			SLOW_OSC_EN <= !sleep_reg; // R6
			FAST_OSC_EN <= fast_run;   // R5 R11
		end
	end

	// start-up counter restarts whenever the fast oscillator stops
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			stable_cnt_reg <= '0;
			stable_reg     <= 1'b0;
		end else if (!fast_run) begin
			stable_cnt_reg <= '0;
			stable_reg     <= 1'b0;
		end else if (stable_cnt_reg >= stable_max) begin
			stable_reg     <= 1'b1; // R16
		end else begin
			stable_cnt_reg <= stable_cnt_reg + 1'b1;
		end
	end

	// oscillator pin synchronisers; first stage feeds only the second
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			slow_sync_reg <= 3'h0;
			fast_sync_reg <= 3'h0;
		end else begin
			slow_sync_reg <= {slow_sync_reg[1:0], SLOW_OSC_IN}; // R4
			fast_sync_reg <= {fast_sync_reg[1:0], FAST_OSC_IN}; // R4
		end
	end

	// a level counts once stages two and three agree
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			slow_lvl_reg <= 1'b0;
			fast_lvl_reg <= 1'b0;
		end else begin
			if (slow_sync_reg[1] == slow_sync_reg[2]) begin
				slow_lvl_reg <= slow_sync_reg[2];
			end
			if (fast_sync_reg[1] == fast_sync_reg[2]) begin
				fast_lvl_reg <= fast_sync_reg[2];
			end
		end
	end

	// source choice: change only when both clocks are low, so no runt pulse, except back to slow at once when the fast oscillator stops
	always_comb begin
		src_next = src_reg;
		if (want_fast && src_reg == clock_source_pkg::SRC_SLOW && both_low) begin
			src_next = clock_source_pkg::SRC_FAST; // R16
		end else if (!want_fast && src_reg == clock_source_pkg::SRC_FAST) begin
			// a stopped fast oscillator cannot be waited on
			if (both_low || !fast_run) begin
				src_next = clock_source_pkg::SRC_SLOW; // R16
			end
		end
	end

	// source register
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			src_reg <= clock_source_pkg::SRC_SLOW; // R1
		end else begin
			src_reg <= src_next;
		end
	end

	// clock outputs and status
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			CPU_CLK        <= 1'b0;
			TIMER_CLK      <= 1'b0;
			CPU_ON_FAST    <= 1'b0;
			FAST_OSC_READY <= 1'b0;
		end else begin
			// cpu clock held low in sleep
			CPU_CLK        <= src_clk && !sleep_reg;
			// timers run from the slow oscillator whatever the cpu source, held low in sleep
			TIMER_CLK      <= slow_lvl_reg && !sleep_reg; // R7
			CPU_ON_FAST    <= (src_reg == clock_source_pkg::SRC_FAST);
			FAST_OSC_READY <= stable_reg;
		end
	end

	// assertions, grouped together after the logic they guard

	// control bits are clear straight after reset
	property p_reset_slow;
		@(posedge CORE_CLK) $fell(RST) |-> (!cpu_sel_reg && !fast_en_reg && src_reg == clock_source_pkg::SRC_SLOW);
	endproperty
	a_reset_slow: assert property (p_reset_slow) else $error("reset did not select slow source"); // R1

	// enable write reaches the oscillator two edges later
	property p_fast_en_write;
		@(posedge CORE_CLK) disable iff (RST)
		(wr_hit && !sleep_reg && !SLEEP_EXEC) |-> ##2 (FAST_OSC_EN == $past(IO_WDATA[2], 2));
	endproperty
	a_fast_en_write: assert property (p_fast_en_write) else $error("fast enable did not follow write"); // R2

	// select write is stored
	property p_sel_write;
		@(posedge CORE_CLK) disable iff (RST)
		wr_hit |=> (cpu_sel_reg == $past(IO_WDATA[3]));
	endproperty
	a_sel_write: assert property (p_sel_write) else $error("select bit did not follow write"); // R3

	// fast oscillator off when enable is clear
	property p_fast_stop;
		@(posedge CORE_CLK) disable iff (RST)
		!fast_en_reg |=> !FAST_OSC_EN;
	endproperty
	a_fast_stop: assert property (p_fast_stop) else $error("fast oscillator ran while disabled"); // R5

	// both oscillators off through sleep
	property p_sleep_stop;
		@(posedge CORE_CLK) disable iff (RST)
		sleep_reg |=> (!SLOW_OSC_EN && !FAST_OSC_EN && !CPU_CLK);
	endproperty
	a_sleep_stop: assert property (p_sleep_stop) else $error("oscillator ran during sleep"); // R6

	// timer clock follows slow level while the cpu is on the fast source
	property p_timer_clk;
		@(posedge CORE_CLK) disable iff (RST)
		(!sleep_reg && src_reg == clock_source_pkg::SRC_FAST) |=> (TIMER_CLK == $past(slow_lvl_reg));
	endproperty
	a_timer_clk: assert property (p_timer_clk) else $error("timer clock lost while on fast source"); // R7

	// disabling after return to slow reaches the oscillator two edges later
	property p_quick_disable;
		@(posedge CORE_CLK) disable iff (RST)
		(wr_hit && !IO_WDATA[2] && src_reg == clock_source_pkg::SRC_SLOW) |-> ##2 !FAST_OSC_EN;
	endproperty
	a_quick_disable: assert property (p_quick_disable) else $error("fast disable was delayed"); // R11

	// unused bits read zero
	property p_unused_zero;
		@(posedge CORE_CLK) disable iff (RST)
		rd_hit |=> (IO_RDATA[1:0] == 2'h0 && IO_RDATA[3] == $past(cpu_sel_reg));
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("read data wrong"); // R13

	// sleep keeps the configuration
	property p_sleep_keep;
		@(posedge CORE_CLK) disable iff (RST)
		(sleep_reg && !wr_hit) |=> ($stable(cpu_sel_reg) && $stable(fast_en_reg));
	endproperty
	a_sleep_keep: assert property (p_sleep_keep) else $error("sleep changed configuration"); // R14

	// switch onto fast only when settled and both clocks low
	property p_switch_safe;
		@(posedge CORE_CLK) disable iff (RST)
		$rose(src_reg) |-> ($past(stable_reg) && !$past(slow_lvl_reg) && !$past(fast_lvl_reg));
	endproperty
	a_switch_safe: assert property (p_switch_safe) else $error("unsafe switch to fast source"); // R16

	// select written before start-up is over keeps the slow source
	property p_early_select;
		@(posedge CORE_CLK) disable iff (RST)
		(cpu_sel_reg && !stable_reg && src_reg == clock_source_pkg::SRC_SLOW) |=> (src_reg == clock_source_pkg::SRC_SLOW);
	endproperty
	a_early_select: assert property (p_early_select) else $error("switched onto unsettled fast source"); // R16

	// on the fast source the cpu clock copies the fast level
	property p_cpu_clk_fast;
		@(posedge CORE_CLK) disable iff (RST)
		(src_reg == clock_source_pkg::SRC_FAST && !sleep_reg) |=> (CPU_CLK == $past(fast_lvl_reg));
	endproperty
	a_cpu_clk_fast: assert property (p_cpu_clk_fast) else $error("cpu clock not from fast source"); // R3

	// no read hit leaves the read data at zero
	property p_rdata_idle;
		@(posedge CORE_CLK) disable iff (RST)
		!rd_hit |=> (IO_RDATA == 4'h0);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read hit"); // R13

	// wake leaves sleep at the next edge
	property p_wake_wins;
		@(posedge CORE_CLK) disable iff (RST)
		WAKE_EVENT |=> !sleep_reg;
	endproperty
	a_wake_wins: assert property (p_wake_wins) else $error("wake did not end sleep"); // R14

	// main scenarios
	c_to_fast:   cover property (@(posedge CORE_CLK) disable iff (RST) $rose(src_reg));
	c_to_slow:   cover property (@(posedge CORE_CLK) disable iff (RST) $fell(src_reg));
	c_sleep_out: cover property (@(posedge CORE_CLK) disable iff (RST) sleep_reg ##1 !sleep_reg);
	c_sleep_in:  cover property (@(posedge CORE_CLK) disable iff (RST) $rose(sleep_reg));
	c_early_sel: cover property (@(posedge CORE_CLK) disable iff (RST) cpu_sel_reg && fast_run && !stable_reg);

endmodule

/* File: osc_model.sv */
// behavioural model of the two external oscillator circuits
// assumes the enables come straight from the clock source block
`timescale 1ns/1ns

module osc_model #(
	parameter int SLOW_HALF = 200, // slow half period, shortened
	parameter int FAST_HALF = 30,  // fast half period, shortened
	parameter int START_NS  = 300  // fast start-up before first edge
) (
	input  wire logic slow_en,
	input  wire logic fast_en,
	output      logic slow_osc,
	output      logic fast_osc
);
	time on_at; // time of the latest fast enable

	// slow oscillator, held low while stopped
	initial begin
		slow_osc = 1'b0;
		forever begin
			#(SLOW_HALF);
			slow_osc = slow_en ? ~slow_osc : 1'b0;
		end
	end

	// start-up measured from every enable, so a quick re-enable restarts it
	initial on_at = 0;
	always @(posedge fast_en) begin
		on_at = $time;
	end

	// fast oscillator, held low while stopped or starting
	initial begin
		fast_osc = 1'b0;
		forever begin
			#(FAST_HALF);
			fast_osc = (fast_en && ($time - on_at >= START_NS)) ? ~fast_osc : 1'b0;
		end
	end
endmodule

/* File: tb_cpu_clock_source_control.sv */
// testbench for the cpu clock source control block
// assumes osc_model on the oscillator pins and a shortened start-up wait
`timescale 1ns/1ns

module tb_cpu_clock_source_control;
	localparam logic [15:0] A = 16'hFF00; // control register address
	logic        clk, rst, wr, rd, sleep_instruction, wake;
	logic [15:0] addr;
	logic [3:0]  wdata, rdata, got;
	logic        slow_in, fast_in, slow_en, fast_en, ready, on_fast, cpu_clk, timer_clk;
	int          error_cnt, checks_done, cycles, e1, e2;

	cpu_clock_source_control #(.STABLE_CYCLES(40), .STABLE_W(20)) dut_u (
		.CORE_CLK(clk), .RST(rst), .IO_ADDR(addr), .IO_WR(wr), .IO_RD(rd), .IO_WDATA(wdata),
		.IO_RDATA(rdata), .SLEEP_EXEC(sleep_instruction), .WAKE_EVENT(wake), .SLOW_OSC_IN(slow_in),
		.FAST_OSC_IN(fast_in), .SLOW_OSC_EN(slow_en), .FAST_OSC_EN(fast_en),
		.FAST_OSC_READY(ready), .CPU_ON_FAST(on_fast), .CPU_CLK(cpu_clk), .TIMER_CLK(timer_clk));
	osc_model osc_u (.slow_en(slow_en), .fast_en(fast_en), .slow_osc(slow_in), .fast_osc(fast_in));

	// core clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// compare and count
	task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// verdict and end of run
	task automatic complete_run();
		if (error_cnt == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// one register write
	task automatic wr_reg(input logic [15:0] a, input logic [3:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask

	// one register read, data one cycle later
	task automatic rd_reg(input logic [15:0] a, output logic [3:0] d);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		d = rdata;
	endtask

	// bounded wait for a level
	task automatic wait_lvl(ref logic s, input logic want, input int lim);
		for (int n = 0; n < lim && s !== want; n++) @(negedge clk);
	endtask

	// count level changes over n cycles
	task automatic edges(ref logic s, input int n, output int e);
		logic last;
		e = 0;
		last = s;
		repeat (n) begin
			@(negedge clk);
			if (s !== last) e++;
			last = s;
		end
	endtask

	// one pulse on a strobe
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask

	// reset values of register and enables
	task automatic t_reset();
		rd_reg(A, got);
		chk(got, 4'h0);
		chk({3'h0, slow_en}, 4'h1);
		chk({3'h0, fast_en}, 4'h0);
		chk({3'h0, on_fast}, 4'h0);
		chk({3'h0, ready}, 4'h0);
		edges(cpu_clk, 60, e1);
		chk({3'h0, e1 >= 2}, 4'h1);
	endtask

	// enable, early select refused, switch to fast
	task automatic t_to_fast();
		wr_reg(A, 4'h7);
		rd_reg(A, got);
		chk(got, 4'h4);
		chk({3'h0, fast_en}, 4'h1);
		wr_reg(A, 4'hC);
		chk({3'h0, on_fast}, 4'h0);
		repeat (25) @(negedge clk);
		chk({3'h0, ready}, 4'h0);
		chk({3'h0, on_fast}, 4'h0);
		wait_lvl(ready, 1'b1, 40);
		chk({3'h0, ready}, 4'h1);
		wait_lvl(on_fast, 1'b1, 80);
		chk({3'h0, on_fast}, 4'h1);
		rd_reg(A, got);
		chk(got, 4'hC);
		edges(timer_clk, 120, e1);
		edges(cpu_clk, 120, e2);
		chk({3'h0, e1 >= 2}, 4'h1);
		chk({3'h0, e2 > e1}, 4'h1);
	endtask

	// back to slow, then oscillator off
	task automatic t_to_slow();
		wr_reg(A, 4'h4);
		wait_lvl(on_fast, 1'b0, 60);
		chk({3'h0, on_fast}, 4'h0);
		wr_reg(A, 4'h0);
		@(negedge clk);
		chk({3'h0, fast_en}, 4'h0);
		rd_reg(A, got);
		chk(got, 4'h0);
	endtask

	// sleep stops both, wake restores configuration
	task automatic t_sleep();
		wr_reg(A, 4'h4);
		wait_lvl(ready, 1'b1, 80);
		chk({3'h0, ready}, 4'h1);
		pulse(sleep_instruction);
		repeat (2) @(negedge clk);
		chk({2'h0, slow_en, fast_en}, 4'h0);
		edges(cpu_clk, 60, e1);
		chk(e1[3:0], 4'h0);
		edges(timer_clk, 60, e2);
		chk(e2[3:0], 4'h0);
		rd_reg(A, got);
		chk(got, 4'h4);
		pulse(wake);
		repeat (2) @(negedge clk);
		chk({1'b0, slow_en, fast_en, on_fast}, 4'h6);
		chk({3'h0, ready}, 4'h0);
	endtask

	// other addresses neither read nor write
	task automatic t_unmapped();
		wr_reg(16'hFF01, 4'hC);
		rd_reg(A, got);
		chk(got, 4'h4);
		rd_reg(16'hFF01, got);
		chk(got, 4'h0);
	endtask

	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			complete_run();
		end
	end

	// main sequence
	initial begin
		{rst, wr, rd, sleep_instruction, wake} = 5'h10;
		addr = 16'h0000;
		wdata = 4'h0;
		error_cnt = 0;
		checks_done = 0;
		cycles = 0;
		repeat (10) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		t_reset();
		t_to_fast();
		t_to_slow();
		t_sleep();
		t_unmapped();
		// second reset from a non-reset configuration
		@(negedge clk);
		rst = 1'b1;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		t_reset();
		complete_run();
	end
endmodule
